// ==== event_combiner.sv ====
// Unlatched combination of the event pin sources into an active-low level.
// Assumes sources are live levels from logic on clk_i, high while active.
`timescale 1ns/1ns
module event_combiner (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Live sources and their enables
	input wire logic [irq_event_pkg::EVT_W-1:0] source_i,
	input wire logic [irq_event_pkg::EVT_W-1:0] enable_i,
	// Combined level, low while any enabled source is active
	output logic event_n_o
);
	import irq_event_pkg::*;

	logic event_n_reg;
	logic event_n_next;

	always_comb begin
		// No memory of past activity: the level only tracks live sources
		event_n_next = ~|(source_i & enable_i); // [RL12] [RL13] [RL14]
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			event_n_reg <= 1'b1;
		end else begin
			event_n_reg <= event_n_next;
		end
	end

	assign event_n_o = event_n_reg;

endmodule : event_combiner

// ==== flag_bank.sv ====
// One group of sticky event flags with write-one-to-clear acknowledge.
// Assumes set pulses and clear writes come from logic on clk_i.
`timescale 1ns/1ns
module flag_bank (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Internal events, one cycle each
	input wire logic [irq_event_pkg::FLAG_W-1:0] set_i,
	// Host acknowledge write
	input wire logic clear_we_i,
	input wire logic [irq_event_pkg::FLAG_W-1:0] clear_data_i,
	// Flag state
	output logic [irq_event_pkg::FLAG_W-1:0] flags_o
);
	import irq_event_pkg::*;

	logic [FLAG_W-1:0] flags_reg;
	logic [FLAG_W-1:0] flags_next;
	logic [FLAG_W-1:0] clear_mask;

	always_comb begin
		clear_mask = clear_we_i ? clear_data_i : '0; // [RL5]
		// Set is applied after the clear so a coincident event survives
		flags_next = (flags_reg & ~clear_mask) | set_i; // [RL4] [RL19]
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flags_reg <= FLAGS_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags_o = flags_reg;

endmodule : flag_bank

// ==== host_ack_model.sv ====
// Host that services line B: reads the flags and acknowledges them.
// Assumes the design clock; slow mode acts only when its four-bit wait counter, which advances on every cycle without an acknowledge, reaches fifteen.
`timescale 1ns/1ns
module host_ack_model
	import irq_event_pkg::*;
(
	// Clock, reset and modes
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic auto_i,
	input wire logic slow_i,
	// View of the device
	input wire logic line_n_i,
	input wire logic [FLAG_W-1:0] flags_i,
	input wire logic [FLAG_W-1:0] enable_i,
	// Acknowledge write
	output logic we_o,
	output logic [FLAG_W-1:0] wdata_o
);
	logic [3:0] wait_reg;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			we_o <= 1'b0;
			wdata_o <= '0;
			wait_reg <= 4'h0;
		end else if (auto_i && !line_n_i && !we_o && (!slow_i || wait_reg == 4'hf)) begin
			// Only the enabled and non-maskable causes are cleared; masked ones stay for polling
			we_o <= 1'b1;
			wdata_o <= flags_i & (enable_i | NONMASK_B);
		end else begin
			we_o <= 1'b0;
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule : host_ack_model

// ==== irq_and_event_pin_logic.sv ====
// Interrupt lines, flag groups, detail registers and shared event pin.
// Assumes all inputs come from logic on clk_i; the host side is a decoded
// register interface delivering one-cycle write strobes.
//
// Contract
// RL1 - Each interrupt line is low while any enabled flag of its group is set.
// RL2 - Each group has a 32-bit enable mask and 32 matching status flags.
// RL3 - Enable bit one passes its flag to the line; zero blocks it.
// RL4 - A flag sets on its event regardless of the enable mask.
// RL5 - Writing ones clears exactly those flags; the line rises when none remain.
// RL6 - Host finds the cause by reading flags and acknowledges by writing ones.
// RL7 - Reset-complete and first fault flags drive their line even when masked.
// RL8 - Merge mode puts both groups on line B; line A keeps its own.
// RL9 - Phase A voltage zero crossing sets a group B flag, line B if enabled.
// RL10 - Shared pin shows the event function only when its select holds 10.
// RL11 - Event pin draws on 16 sources, each with an enable, all cleared at reset.
// RL12 - Event pin low while any enabled source active, high once all inactive.
// RL13 - Event sources are unlatched; one enabled source is tracked directly.
// RL14 - Event pin level depends only on enabled sources, no user polarity.
// RL15 - Overcurrent flag comes with per-phase overcurrent detail bits.
// RL16 - Six idle flags of group B come with per-phase idle detail bits.
// RL17 - Reverse power flags of group A come with sign detail bits.
// RL18 - Host reads the detail register after seeing its associated flag.
// RL19 - A set in the same cycle as a clear wins, no event is lost.
`timescale 1ns/1ns
module irq_and_event_pin_logic (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Internal event pulses per group
	input wire logic [irq_event_pkg::FLAG_W-1:0] event_set_a_i,
	input wire logic [irq_event_pkg::FLAG_W-1:0] event_set_b_i,
	// Host acknowledge writes to the flag groups
	input wire logic event_flags_a_we_i,
	input wire logic [irq_event_pkg::FLAG_W-1:0] event_flags_a_wdata_i,
	input wire logic event_flags_b_we_i,
	input wire logic [irq_event_pkg::FLAG_W-1:0] event_flags_b_wdata_i,
	// Host writes to the enable masks
	input wire logic int_enable_a_we_i,
	input wire logic [irq_event_pkg::FLAG_W-1:0] int_enable_a_wdata_i,
	input wire logic int_enable_b_we_i,
	input wire logic [irq_event_pkg::FLAG_W-1:0] int_enable_b_wdata_i,
	// Host write to the setup fields
	input wire logic setup_reg_one_we_i,
	input wire logic merge_int_lines_wdata_i,
	input wire logic [irq_event_pkg::PIN_SEL_W-1:0] pin4_function_sel_wdata_i,
	// Host write to the event source enables
	input wire logic event_enable_we_i,
	input wire logic [irq_event_pkg::EVT_W-1:0] event_enable_wdata_i,
	// Live event sources and other shared pin functions
	input wire logic [irq_event_pkg::EVT_W-1:0] event_source_i,
	input wire logic pulse_out_four_i,
	input wire logic sample_ready_out_i,
	// Live detail inputs from the measurement logic
	input wire logic [irq_event_pkg::OC_DETAIL_W-1:0] overcurrent_phase_bits_i,
	input wire logic [irq_event_pkg::IDLE_DETAIL_W-1:0] phase_idle_bits_i,
	input wire logic [irq_event_pkg::SIGN_DETAIL_W-1:0] phase_sign_bits_i,
	// Interrupt lines, active low
	output logic int_out_a_n_o,
	output logic int_out_b_n_o,
	// Shared pulse, event or ready pin
	output logic shared_pin_o,
	// Readback of flag groups
	output logic [irq_event_pkg::FLAG_W-1:0] event_flags_a_o,
	output logic [irq_event_pkg::FLAG_W-1:0] event_flags_b_o,
	// Readback of configuration
	output logic [irq_event_pkg::FLAG_W-1:0] int_enable_a_o,
	output logic [irq_event_pkg::FLAG_W-1:0] int_enable_b_o,
	output logic merge_int_lines_o,
	output logic [irq_event_pkg::PIN_SEL_W-1:0] pin4_function_sel_o,
	output logic [irq_event_pkg::EVT_W-1:0] event_enable_o,
	// Detail registers
	output logic [irq_event_pkg::OC_DETAIL_W-1:0] overcurrent_detail_reg_o,
	output logic [irq_event_pkg::IDLE_DETAIL_W-1:0] phase_idle_detail_o,
	output logic [irq_event_pkg::SIGN_DETAIL_W-1:0] phase_sign_detail_o
);
	import irq_event_pkg::*;

	// Detail bits accumulate while their flag is pending. An
	// acknowledge with no new event empties them, so a stale phase is
	// never reported against a later event.
	function automatic logic [IDLE_DETAIL_W-1:0] detail_step(
		input logic [IDLE_DETAIL_W-1:0] cur,
		input logic hit,
		input logic ack,
		input logic [IDLE_DETAIL_W-1:0] live
	);
		logic [IDLE_DETAIL_W-1:0] kept;
		kept = ack ? '0 : cur;
		detail_step = hit ? (kept | live) : kept;
	endfunction : detail_step

	// Line request of one group: any set flag that is enabled or cannot be masked
	function automatic logic any_pending(
		input logic [FLAG_W-1:0] flags,
		input logic [FLAG_W-1:0] enable,
		input logic [FLAG_W-1:0] nonmask
	);
		any_pending = |(flags & (enable | nonmask));
	endfunction : any_pending

	// Configuration state
	logic [FLAG_W-1:0] int_enable_a_reg;
	logic [FLAG_W-1:0] int_enable_a_next;
	logic [FLAG_W-1:0] int_enable_b_reg;
	logic [FLAG_W-1:0] int_enable_b_next;
	logic merge_int_lines_reg;
	logic merge_int_lines_next;
	logic [PIN_SEL_W-1:0] pin4_function_sel_reg;
	logic [PIN_SEL_W-1:0] pin4_function_sel_next;
	logic [EVT_W-1:0] event_enable_reg;
	logic [EVT_W-1:0] event_enable_next;

	// Flag groups
	logic [FLAG_W-1:0] event_flags_a;
	logic [FLAG_W-1:0] event_flags_b;

	// Interrupt line state
	logic int_out_a_n_reg;
	logic int_out_a_n_next;
	logic int_out_b_n_reg;
	logic int_out_b_n_next;
	logic pending_a;
	logic pending_b;

	// Detail state
	logic [OC_DETAIL_W-1:0] overcurrent_detail_reg;
	logic [OC_DETAIL_W-1:0] overcurrent_detail_next;
	logic [IDLE_DETAIL_W-1:0] phase_idle_detail_reg;
	logic [IDLE_DETAIL_W-1:0] phase_idle_detail_next;
	logic [SIGN_DETAIL_W-1:0] phase_sign_detail_reg;
	logic [SIGN_DETAIL_W-1:0] phase_sign_detail_next;
	logic oc_hit;
	logic oc_ack;
	logic idle_hit;
	logic idle_ack;
	logic sign_hit;
	logic sign_ack;
	logic [IDLE_DETAIL_W-1:0] oc_wide;
	logic [IDLE_DETAIL_W-1:0] sign_wide;

	// Shared pin state
	logic event_n;
	logic shared_pin_reg;
	logic shared_pin_next;

	// Enable mask of group A
	always_comb begin
		int_enable_a_next = int_enable_a_reg;
		if (int_enable_a_we_i) begin
			int_enable_a_next = int_enable_a_wdata_i; // [RL2] [RL3]
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			int_enable_a_reg <= ENABLE_RESET;
		end else begin
			int_enable_a_reg <= int_enable_a_next;
		end
	end

	// Enable mask of group B
	always_comb begin
		int_enable_b_next = int_enable_b_reg;
		if (int_enable_b_we_i) begin
			int_enable_b_next = int_enable_b_wdata_i; // [RL2] [RL3]
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			int_enable_b_reg <= ENABLE_RESET;
		end else begin
			int_enable_b_reg <= int_enable_b_next;
		end
	end

	// Setup fields, always written together
	always_comb begin
		merge_int_lines_next = merge_int_lines_reg;
		pin4_function_sel_next = pin4_function_sel_reg;
		if (setup_reg_one_we_i) begin
			merge_int_lines_next = merge_int_lines_wdata_i; // [RL8]
			pin4_function_sel_next = pin4_function_sel_wdata_i; // [RL10]
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			merge_int_lines_reg <= 1'b0;
			pin4_function_sel_reg <= PIN_SEL_RESET;
		end else begin
			merge_int_lines_reg <= merge_int_lines_next;
			pin4_function_sel_reg <= pin4_function_sel_next;
		end
	end

	// Event source enables, all off after reset
	always_comb begin
		event_enable_next = event_enable_reg;
		if (event_enable_we_i) begin
			event_enable_next = event_enable_wdata_i; // [RL11]
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			event_enable_reg <= EVT_ENABLE_RESET; // [RL11]
		end else begin
			event_enable_reg <= event_enable_next;
		end
	end

	// Flag groups; zero crossing arrives as an ordinary group B event
	flag_bank bank_a (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.set_i(event_set_a_i),
		.clear_we_i(event_flags_a_we_i),
		.clear_data_i(event_flags_a_wdata_i),
		.flags_o(event_flags_a)
	);

	flag_bank bank_b (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.set_i(event_set_b_i), // [RL9]
		.clear_we_i(event_flags_b_we_i),
		.clear_data_i(event_flags_b_wdata_i),
		.flags_o(event_flags_b)
	);

	// Interrupt lines follow the registered flags one cycle later
	always_comb begin
		pending_a = any_pending(event_flags_a, int_enable_a_reg, NONMASK_A); // [RL1] [RL3] [RL7]
		pending_b = any_pending(event_flags_b, int_enable_b_reg, NONMASK_B); // [RL1] [RL7] [RL9]
		int_out_a_n_next = ~pending_a; // [RL5]
		// Line A is unaffected by merging; only line B gains group A
		int_out_b_n_next = ~(pending_b | (merge_int_lines_reg & pending_a)); // [RL8] [RL5]
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			int_out_a_n_reg <= 1'b1;
			int_out_b_n_reg <= 1'b1;
		end else begin
			int_out_a_n_reg <= int_out_a_n_next;
			int_out_b_n_reg <= int_out_b_n_next;
		end
	end

	// Overcurrent detail beside its group B flag
	always_comb begin
		oc_hit = event_set_b_i[OVERCURRENT_POS];
		oc_ack = event_flags_b_we_i & event_flags_b_wdata_i[OVERCURRENT_POS];
		oc_wide = {{(IDLE_DETAIL_W-OC_DETAIL_W){1'b0}}, overcurrent_detail_reg};
		overcurrent_detail_next = OC_DETAIL_W'(detail_step(oc_wide, oc_hit, oc_ack,
			IDLE_DETAIL_W'(overcurrent_phase_bits_i))); // [RL15]
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			overcurrent_detail_reg <= '0;
		end else begin
			overcurrent_detail_reg <= overcurrent_detail_next;
		end
	end

	// Idle detail beside the six idle flags of group B
	always_comb begin
		idle_hit = |(event_set_b_i & IDLE_GROUP_B);
		idle_ack = event_flags_b_we_i & |(event_flags_b_wdata_i & IDLE_GROUP_B);
		phase_idle_detail_next = detail_step(phase_idle_detail_reg, idle_hit, idle_ack,
			phase_idle_bits_i); // [RL16]
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase_idle_detail_reg <= '0;
		end else begin
			phase_idle_detail_reg <= phase_idle_detail_next;
		end
	end

	// Sign detail beside the reverse power flags of group A
	always_comb begin
		sign_hit = |(event_set_a_i & REVERSE_GROUP_A);
		sign_ack = event_flags_a_we_i & |(event_flags_a_wdata_i & REVERSE_GROUP_A);
		sign_wide = detail_step(IDLE_DETAIL_W'(phase_sign_detail_reg), sign_hit, sign_ack,
			IDLE_DETAIL_W'(phase_sign_bits_i));
		phase_sign_detail_next = SIGN_DETAIL_W'(sign_wide); // [RL17]
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase_sign_detail_reg <= '0;
		end else begin
			phase_sign_detail_reg <= phase_sign_detail_next;
		end
	end

	// Event level, then the pin function multiplexer
	event_combiner combiner (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.source_i(event_source_i),
		.enable_i(event_enable_reg), // [RL11]
		.event_n_o(event_n)
	);

	always_comb begin
		unique case (pin4_function_sel_reg)
			PIN_SEL_PULSE: begin
				shared_pin_next = pulse_out_four_i;
			end
			PIN_SEL_EVENT: begin
				shared_pin_next = event_n; // [RL10] [RL14]
			end
			default: begin
				// Both remaining codes give the ready function
				shared_pin_next = sample_ready_out_i;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			shared_pin_reg <= 1'b1;
		end else begin
			shared_pin_reg <= shared_pin_next;
		end
	end

	// Outputs, all from flip-flops
	assign int_out_a_n_o = int_out_a_n_reg;
	assign int_out_b_n_o = int_out_b_n_reg;
	assign shared_pin_o = shared_pin_reg;
	assign event_flags_a_o = event_flags_a;
	assign event_flags_b_o = event_flags_b;
	assign int_enable_a_o = int_enable_a_reg;
	assign int_enable_b_o = int_enable_b_reg;
	assign merge_int_lines_o = merge_int_lines_reg;
	assign pin4_function_sel_o = pin4_function_sel_reg;
	assign event_enable_o = event_enable_reg;
	assign overcurrent_detail_reg_o = overcurrent_detail_reg;
	assign phase_idle_detail_o = phase_idle_detail_reg;
	assign phase_sign_detail_o = phase_sign_detail_reg;

endmodule : irq_and_event_pin_logic

// ==== irq_event_pkg.sv ====
// Constants shared by the interrupt and event pin logic.
// Assumes the users import the whole package; all counts are in bits.
package irq_event_pkg;

	// Width of each interrupt group
	localparam int unsigned FLAG_W = 32;
	// Number of event pin sources
	localparam int unsigned EVT_W = 16;
	// Detail register widths
	localparam int unsigned OC_DETAIL_W = 3;
	localparam int unsigned IDLE_DETAIL_W = 9;
	localparam int unsigned SIGN_DETAIL_W = 9;

	// Group B flag positions
	localparam int unsigned TOTAL_ACTIVE_IDLE_POS = 0;
	localparam int unsigned TOTAL_REACTIVE_IDLE_POS = 1;
	localparam int unsigned TOTAL_APPARENT_IDLE_POS = 2;
	localparam int unsigned FUND_ACTIVE_IDLE_POS = 3;
	localparam int unsigned FUND_REACTIVE_IDLE_POS = 4;
	localparam int unsigned FUND_APPARENT_IDLE_POS = 5;
	localparam int unsigned ZERO_CROSS_A_VOLT_POS = 9;
	localparam int unsigned RESET_COMPLETE_POS = 16;
	localparam int unsigned OVERCURRENT_POS = 17;
	localparam int unsigned FAULT_A_POS = 18;

	// Group A flag positions, three phases each starting at the base
	localparam int unsigned REVERSE_ACTIVE_POS = 6;
	localparam int unsigned REVERSE_REACTIVE_POS = 9;
	localparam int unsigned REVERSE_SUM_POS = 12;
	localparam int unsigned PHASES = 3;

	// Flags that reach their line whatever the enable mask says
	localparam logic [FLAG_W-1:0] NONMASK_A = 32'h0000_0000;
	localparam logic [FLAG_W-1:0] NONMASK_B = 32'h0005_0000;

	// Flags that update the detail registers
	localparam logic [FLAG_W-1:0] IDLE_GROUP_B = 32'h0000_003f;
	localparam logic [FLAG_W-1:0] REVERSE_GROUP_A = 32'h0000_7fc0;

	// Reset values
	localparam logic [FLAG_W-1:0] FLAGS_RESET = 32'h0000_0000;
	localparam logic [FLAG_W-1:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [EVT_W-1:0] EVT_ENABLE_RESET = 16'h0000;

	// Shared pin function select encodings
	localparam int unsigned PIN_SEL_W = 2;
	localparam logic [PIN_SEL_W-1:0] PIN_SEL_PULSE = 2'h0;
	localparam logic [PIN_SEL_W-1:0] PIN_SEL_READY = 2'h1;
	localparam logic [PIN_SEL_W-1:0] PIN_SEL_EVENT = 2'h2;
	localparam logic [PIN_SEL_W-1:0] PIN_SEL_RESET = 2'h0;

endpackage : irq_event_pkg

// ==== irq_pins_monitor.sv ====
// Checker for the interrupt lines, flag group B and the shared pin.
// Assumes one clock domain and the constants of the shared package.
`timescale 1ns/1ns
module irq_pins_monitor
	import irq_event_pkg::*;
(
	// Clock, reset and inputs
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [FLAG_W-1:0] event_set_b_i,
	input wire logic event_flags_b_we_i,
	input wire logic [FLAG_W-1:0] event_flags_b_wdata_i,
	input wire logic int_enable_b_we_i,
	input wire logic [FLAG_W-1:0] int_enable_b_wdata_i,
	input wire logic [EVT_W-1:0] event_source_i,
	input wire logic [OC_DETAIL_W-1:0] overcurrent_phase_bits_i,
	// Outputs
	input wire logic int_out_a_n_o,
	input wire logic int_out_b_n_o,
	input wire logic shared_pin_o,
	input wire logic [FLAG_W-1:0] event_flags_a_o,
	input wire logic [FLAG_W-1:0] event_flags_b_o,
	input wire logic [FLAG_W-1:0] int_enable_a_o,
	input wire logic [FLAG_W-1:0] int_enable_b_o,
	input wire logic merge_int_lines_o,
	input wire logic [PIN_SEL_W-1:0] pin4_function_sel_o,
	input wire logic [EVT_W-1:0] event_enable_o,
	input wire logic [OC_DETAIL_W-1:0] overcurrent_detail_reg_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	set_wins_a: assert property (
		event_set_b_i != '0 |=> (event_flags_b_o & $past(event_set_b_i)) == $past(event_set_b_i)
	) else $error("set flag missing");
	clear_exact_a: assert property (
		event_flags_b_we_i |=> event_flags_b_o ==
			(($past(event_flags_b_o) & ~$past(event_flags_b_wdata_i)) | $past(event_set_b_i))
	) else $error("clear wrong");
	line_a_a: assert property (
		int_out_a_n_o == ~|$past(event_flags_a_o & int_enable_a_o)
	) else $error("line a wrong");
	line_b_a: assert property (
		int_out_b_n_o == ~|$past((event_flags_b_o & (int_enable_b_o | NONMASK_B)) |
			(event_flags_a_o & int_enable_a_o & {FLAG_W{merge_int_lines_o}}))
	) else $error("line b wrong");
	mask_load_a: assert property (
		int_enable_b_we_i |=> int_enable_b_o == $past(int_enable_b_wdata_i)
	) else $error("mask not loaded");
	event_pin_a: assert property (
		$past(pin4_function_sel_o) == PIN_SEL_EVENT |-> shared_pin_o == ~|$past(event_source_i & event_enable_o, 2)
	) else $error("event pin wrong");
	reset_clear_a: assert property (
		$rose(reset_n_i) |-> event_enable_o == EVT_ENABLE_RESET && event_flags_b_o == FLAGS_RESET
	) else $error("reset values wrong");
	oc_detail_a: assert property (
		event_set_b_i[OVERCURRENT_POS] && !event_flags_b_we_i |=>
			(overcurrent_detail_reg_o & $past(overcurrent_phase_bits_i)) == $past(overcurrent_phase_bits_i)
	) else $error("detail bits lost");
	merge_c: cover property (merge_int_lines_o && !int_out_b_n_o && int_out_a_n_o);
	pin_low_c: cover property (pin4_function_sel_o == PIN_SEL_EVENT && !shared_pin_o);
	set_clear_c: cover property (event_flags_b_we_i && (event_set_b_i & event_flags_b_wdata_i) != '0);
endmodule : irq_pins_monitor

bind irq_and_event_pin_logic irq_pins_monitor irq_pins_monitor_inst (.clk_i, .reset_n_i, .event_set_b_i,
	.event_flags_b_we_i, .event_flags_b_wdata_i, .int_enable_b_we_i, .int_enable_b_wdata_i, .event_source_i,
	.overcurrent_phase_bits_i, .int_out_a_n_o, .int_out_b_n_o, .shared_pin_o, .event_flags_a_o, .event_flags_b_o,
	.int_enable_a_o, .int_enable_b_o, .merge_int_lines_o, .pin4_function_sel_o, .event_enable_o,
	.overcurrent_detail_reg_o);

// ==== tb.sv ====
// Random traffic on every input but reset, pulsed mid-run, and the group B acknowledge, which the host model drives; a cycle model is compared each cycle.
// Assumes the package, design, host model and checker are compiled first.
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
	import irq_event_pkg::*;
	logic clk_i = 1'b0, reset_n_i = 1'b0, event_flags_a_we_i = 1'b0, int_enable_a_we_i = 1'b0;
	logic int_enable_b_we_i = 1'b0, setup_reg_one_we_i = 1'b0, merge_int_lines_wdata_i = 1'b0;
	logic event_enable_we_i = 1'b0, pulse_out_four_i = 1'b0, sample_ready_out_i = 1'b0, auto_ack = 1'b0, slow = 1'b0;
	logic [31:0] event_set_a_i = '0, event_set_b_i = '0, event_flags_a_wdata_i = '0;
	logic [31:0] int_enable_a_wdata_i = '0, int_enable_b_wdata_i = '0, event_flags_b_wdata_i;
	logic [1:0] pin4_function_sel_wdata_i = 2'h0, pin4_function_sel_o, sel;
	logic [15:0] event_enable_wdata_i = '0, event_source_i = '0, event_enable_o, ev;
	logic [2:0] overcurrent_phase_bits_i = 3'h0, overcurrent_detail_reg_o;
	logic [8:0] phase_idle_bits_i = '0, phase_sign_bits_i = '0, phase_idle_detail_o, phase_sign_detail_o, doc, did, dsg;
	logic event_flags_b_we_i, int_out_a_n_o, int_out_b_n_o, shared_pin_o, merge_int_lines_o, mg, la, lb, cmb, pin;
	logic [31:0] event_flags_a_o, event_flags_b_o, int_enable_a_o, int_enable_b_o, fa, fb, ma, mb;
	integer seed = 65759, failures = 0, compares = 0;

	always #5 clk_i = ~clk_i;

	irq_and_event_pin_logic irq_and_event_pin_logic_inst (.clk_i, .reset_n_i, .event_set_a_i, .event_set_b_i,
		.event_flags_a_we_i, .event_flags_a_wdata_i, .event_flags_b_we_i, .event_flags_b_wdata_i, .int_enable_a_we_i,
		.int_enable_a_wdata_i, .int_enable_b_we_i, .int_enable_b_wdata_i, .setup_reg_one_we_i, .merge_int_lines_wdata_i,
		.pin4_function_sel_wdata_i, .event_enable_we_i, .event_enable_wdata_i, .event_source_i, .pulse_out_four_i,
		.sample_ready_out_i, .overcurrent_phase_bits_i, .phase_idle_bits_i, .phase_sign_bits_i, .int_out_a_n_o,
		.int_out_b_n_o, .shared_pin_o, .event_flags_a_o, .event_flags_b_o, .int_enable_a_o, .int_enable_b_o,
		.merge_int_lines_o, .pin4_function_sel_o, .event_enable_o, .overcurrent_detail_reg_o, .phase_idle_detail_o,
		.phase_sign_detail_o);
	host_ack_model host_ack_model_inst (.clk_i, .reset_n_i, .auto_i(auto_ack), .slow_i(slow), .line_n_i(int_out_b_n_o),
		.flags_i(event_flags_b_o), .enable_i(int_enable_b_o), .we_o(event_flags_b_we_i), .wdata_o(event_flags_b_wdata_i));

	function automatic logic [31:0] rn();
		rn = $random(seed);
	endfunction : rn

	// Detail bits pile up until acknowledged; an event on the ack edge survives
	function automatic logic [8:0] det(input logic [8:0] cur, input logic hit, input logic ack, input logic [8:0] live);
		return ack ? (hit ? live : 9'h000) : (hit ? cur | live : cur);
	endfunction : det

	// Model reads the inputs before this edge's updates land, as the design does
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			{fa, fb, ma, mb, ev, doc, did, dsg} = '0;
			{mg, sel, la, lb, cmb, pin} = {1'b0, PIN_SEL_RESET, 4'hf};
		end else begin
			la = ~|(fa & (ma | NONMASK_A));
			lb = ~|((fb & (mb | NONMASK_B)) | (mg ? fa & (ma | NONMASK_A) : '0));
			pin = sel == PIN_SEL_EVENT ? cmb : sel == PIN_SEL_PULSE ? pulse_out_four_i : sample_ready_out_i;
			cmb = ~|(event_source_i & ev);
			doc = det(doc, event_set_b_i[OVERCURRENT_POS], event_flags_b_we_i & event_flags_b_wdata_i[OVERCURRENT_POS],
				{6'h00, overcurrent_phase_bits_i});
			did = det(did, |(event_set_b_i & IDLE_GROUP_B), event_flags_b_we_i & |(event_flags_b_wdata_i & IDLE_GROUP_B),
				phase_idle_bits_i);
			dsg = det(dsg, |(event_set_a_i & REVERSE_GROUP_A),
				event_flags_a_we_i & |(event_flags_a_wdata_i & REVERSE_GROUP_A), phase_sign_bits_i);
			fa = (fa & ~(event_flags_a_we_i ? event_flags_a_wdata_i : '0)) | event_set_a_i;
			fb = (fb & ~(event_flags_b_we_i ? event_flags_b_wdata_i : '0)) | event_set_b_i;
			if (int_enable_a_we_i) ma = int_enable_a_wdata_i;
			if (int_enable_b_we_i) mb = int_enable_b_wdata_i;
			if (setup_reg_one_we_i) {mg, sel} = {merge_int_lines_wdata_i, pin4_function_sel_wdata_i};
			if (event_enable_we_i) ev = event_enable_wdata_i;
		end
	end

	always @(negedge clk_i) begin
		`CHK("flags_a", fa, event_flags_a_o)
		`CHK("flags_b", fb, event_flags_b_o)
		`CHK("line_a", la, int_out_a_n_o)
		`CHK("line_b", lb, int_out_b_n_o)
		`CHK("masks", {ma, mb}, {int_enable_a_o, int_enable_b_o})
		`CHK("setup", {mg, sel, ev}, {merge_int_lines_o, pin4_function_sel_o, event_enable_o})
		`CHK("pin", pin, shared_pin_o)
		`CHK("oc_detail", doc[2:0], overcurrent_detail_reg_o)
		`CHK("idle_detail", did, phase_idle_detail_o)
		`CHK("sign_detail", dsg, phase_sign_detail_o)
	end

	task automatic report_and_stop();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		for (int i = 0; i < 6000; i++) begin
			@(posedge clk_i);
			reset_n_i <= !(i inside {[3000:3002]});
			event_set_a_i <= rn() & rn() & rn() & rn();
			event_set_b_i <= rn() & rn() & rn() & rn() & rn();
			event_flags_a_we_i <= rn() % 4 == 0;
			event_flags_a_wdata_i <= rn();
			int_enable_a_we_i <= rn() % 16 == 0;
			int_enable_a_wdata_i <= rn();
			int_enable_b_we_i <= rn() % 16 == 0;
			int_enable_b_wdata_i <= rn() & rn();
			setup_reg_one_we_i <= rn() % 64 == 0;
			merge_int_lines_wdata_i <= 1'(rn());
			pin4_function_sel_wdata_i <= 2'(rn());
			event_enable_we_i <= rn() % 64 == 0;
			event_enable_wdata_i <= 16'(rn() & rn());
			event_source_i <= event_source_i ^ 16'(rn() & rn() & rn());
			pulse_out_four_i <= 1'(rn());
			sample_ready_out_i <= 1'(rn());
			overcurrent_phase_bits_i <= 3'(rn());
			phase_idle_bits_i <= 9'(rn());
			phase_sign_bits_i <= 9'(rn());
			auto_ack <= i % 2000 < 1500;
			slow <= i % 1000 < 500;
		end
		report_and_stop();
	end
endmodule : tb
